// ==== test/plpd_ctrl_regs_properties.sv ====
// assertion checker for the pll/power-down register bank
`timescale 1ns/1ps

module plpd_chk (
    // clock and reset
    input wire        clk_sys,
    input wire        reset_n,
    // configuration port
    input wire [15:0] cfg_addr,
    input wire        cfg_wr,
    input wire [7:0]  cfg_wdata,
    input wire        cfg_rd,
    input wire [7:0]  cfg_rdata,
    input wire        cfg_rvalid,
    // lock status and fields
    input wire        pll_locked_raw,
    input wire [4:0]  pump_current_code,
    input wire [3:0]  output_driver_off,
    input wire [1:0]  reference_input_off,
    input wire        lock_alarm_release_mode,
    input wire        loss_of_lock_alarm,
    input wire        lock_loss_sticky_flag
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    property p_rd; cfg_rd |=> cfg_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("no read answer");
    property p_quiet; !cfg_rd |=> !cfg_rvalid && $stable(cfg_rdata); endproperty
    a_quiet: assert property (p_quiet) else $error("stray answer");
    property p_unmap; cfg_rd && cfg_addr == 16'h0068 |=> cfg_rdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped data");
    property p_pump; cfg_wr && cfg_addr == 16'h006C |=>
        pump_current_code == $past(cfg_wdata[4:0]); endproperty
    a_pump: assert property (p_pump) else $error("pump code");
    property p_outs; cfg_wr && cfg_addr == 16'h006F |=>
        output_driver_off == $past(cfg_wdata[3:0]); endproperty
    a_outs: assert property (p_outs) else $error("output disables");
    property p_ref; cfg_wr && cfg_addr == 16'h006D |=>
        {lock_alarm_release_mode, reference_input_off} ==
        {$past(cfg_wdata[7]), $past(cfg_wdata[1:0])}; endproperty
    a_ref: assert property (p_ref) else $error("reference bits");
    property p_hold; !cfg_wr |=>
        $stable(output_driver_off) && $stable(pump_current_code); endproperty
    a_hold: assert property (p_hold) else $error("field moved");
    // lock loss raises alarm and record
    property p_loss; $fell(pll_locked_raw) |->
        ##[1:5] (loss_of_lock_alarm && lock_loss_sticky_flag); endproperty
    a_loss: assert property (p_loss) else $error("no lock alarm");
    property p_stick; lock_loss_sticky_flag &&
        !(cfg_wr && cfg_addr == 16'h0200 && cfg_wdata[6])
        |=> lock_loss_sticky_flag; endproperty
    a_stick: assert property (p_stick) else $error("record lost");
endmodule // plpd_chk

bind plpd_ctrl_regs plpd_chk u_chk (
    .clk_sys                 (clk_sys),
    .reset_n                 (reset_n),
    .cfg_addr                (cfg_addr),
    .cfg_wr                  (cfg_wr),
    .cfg_wdata               (cfg_wdata),
    .cfg_rd                  (cfg_rd),
    .cfg_rdata               (cfg_rdata),
    .cfg_rvalid              (cfg_rvalid),
    .pll_locked_raw          (pll_locked_raw),
    .pump_current_code       (pump_current_code),
    .output_driver_off       (output_driver_off),
    .reference_input_off     (reference_input_off),
    .lock_alarm_release_mode (lock_alarm_release_mode),
    .loss_of_lock_alarm      (loss_of_lock_alarm),
    .lock_loss_sticky_flag   (lock_loss_sticky_flag)
);

// ==== test/tb_plpd_ctrl_regs.sv ====
// self-checking bench for the pll/power-down register bank
`timescale 1ns/1ps

`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
    $display("wrong value at %0t: %h %h", $time, a, b); end end

module tb_plpd_ctrl_regs;
    // design ports
    logic        clk_sys = 0, reset_n = 0, cfg_wr = 0, cfg_rd = 0;
    logic [15:0] cfg_addr = 0;
    logic [7:0]  cfg_wdata = 0;
    logic        pll_locked_raw = 1, out_clocks_stable_raw = 1;
    wire  [7:0]  cfg_rdata;
    wire         cfg_rvalid, lock_override_mode, lock_alarm_release_mode;
    wire  [2:0]  manual_oscillator_choice;
    wire  [4:0]  manual_lock_value, pump_current_code;
    wire  [1:0]  reference_input_off;
    wire  [3:0]  output_driver_off;
    wire         crystal_doubler_bypass, digital_loop_off, modulator_off;
    wire         calibration_hold, loss_of_lock_alarm, lock_loss_sticky_flag;
    // bench state: written values, read notes
    int          error_cnt = 0, n_compared = 0, cyc = 0;
    logic [7:0]  exp_q[$], xm;
    logic [7:0]  v[9] = '{8'h00, 8'h2B, 0, 0, 0, 0, 0, 0, 0};
    logic [15:0] ad[9] = '{16'h0069, 16'h006A, 16'h006C, 16'h006D, 16'h006E,
                           16'h006F, 16'h0070, 16'h0200, 16'h0068};
    logic [7:0]  mk[9] = '{8'h01, 8'h3F, 8'h1F, 8'h83, 8'h01, 8'h0F, 8'h07,
                           8'h00, 8'h00};
    // all control fields (not alarm or sticky flag) against the values last written
    wire  [24:0] flds = {lock_override_mode, manual_oscillator_choice,
        manual_lock_value, pump_current_code, reference_input_off,
        lock_alarm_release_mode, crystal_doubler_bypass, output_driver_off,
        digital_loop_off, modulator_off, calibration_hold};
    wire  [24:0] exp_f = {v[0][0], v[1], v[2][4:0], v[3][1:0], v[3][7],
        v[4][0], v[5][3:0], v[6][2:0]};

    plpd_ctrl_regs DUT (
        .clk_sys                  (clk_sys),
        .reset_n                  (reset_n),
        .cfg_addr                 (cfg_addr),
        .cfg_wr                   (cfg_wr),
        .cfg_wdata                (cfg_wdata),
        .cfg_rd                   (cfg_rd),
        .cfg_rdata                (cfg_rdata),
        .cfg_rvalid               (cfg_rvalid),
        .pll_locked_raw           (pll_locked_raw),
        .out_clocks_stable_raw    (out_clocks_stable_raw),
        .lock_override_mode       (lock_override_mode),
        .manual_oscillator_choice (manual_oscillator_choice),
        .manual_lock_value        (manual_lock_value),
        .pump_current_code        (pump_current_code),
        .reference_input_off      (reference_input_off),
        .lock_alarm_release_mode  (lock_alarm_release_mode),
        .crystal_doubler_bypass   (crystal_doubler_bypass),
        .output_driver_off        (output_driver_off),
        .digital_loop_off         (digital_loop_off),
        .modulator_off            (modulator_off),
        .calibration_hold         (calibration_hold),
        .loss_of_lock_alarm       (loss_of_lock_alarm),
        .lock_loss_sticky_flag    (lock_loss_sticky_flag)
    );

    always #25 clk_sys = ~clk_sys;

    // one byte access; a read leaves its expected answer as a note
    task bus(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #5;
        cfg_wr = w;
        cfg_rd = !w;
        cfg_addr = a;
        cfg_wdata = d;
        @(posedge clk_sys);
        #5;
        cfg_wr = 0;
        cfg_rd = 0;
        if (!w) exp_q.push_back(d);
    endtask

    task idle(input int n);
        repeat (n) @(posedge clk_sys);
        #5;
    endtask

    task stop_test();
        // a read that never got its answer counts as a mismatch
        if (exp_q.size() != 0) error_cnt++;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // compare each read answer with the oldest note
    always @(negedge clk_sys) begin
        if (cfg_rvalid === 1'b1) begin
            xm = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
            `CHK(cfg_rdata, xm)
        end
    end

    // hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            stop_test();
        end
    end

    initial begin
        void'($urandom(85));
        repeat (3) @(posedge clk_sys);
        #5;
        reset_n = 1;
        // round 0 reads reset values, later rounds write random data
        for (int r = 0; r < 6; r++) begin
            foreach (ad[i]) begin
                if (r > 0) begin
                    v[i] = 8'($urandom()) & mk[i];
                    bus(1, ad[i], v[i]);
                end
                `CHK(flds, exp_f)
                bus(0, ad[i], v[i] & mk[i]);
            end
            $display("test map round %0d done", r);
        end
        // lock loss in both release modes
        for (int m = 0; m < 2; m++) begin
            v[3] = {m[0], 7'h00};
            bus(1, 16'h006D, v[3]);
            out_clocks_stable_raw = 0;
            pll_locked_raw = 0;
            idle(6);
            `CHK({loss_of_lock_alarm, lock_loss_sticky_flag}, 2'b11)
            // clear while lock is still lost: the set must win
            bus(1, 16'h0200, 8'h40);
            `CHK(lock_loss_sticky_flag, 1'b1)
            pll_locked_raw = 1;
            idle(6);
            `CHK(loss_of_lock_alarm, m[0])
            out_clocks_stable_raw = 1;
            idle(6);
            `CHK(loss_of_lock_alarm, 1'b0)
            bus(0, 16'h0200, 8'h40);
            bus(1, 16'h0200, 8'h40);
            `CHK(lock_loss_sticky_flag, 1'b0)
            $display("test lock mode %0d done", m);
        end
        idle(4);
        stop_test();
    end
endmodule // tb_plpd_ctrl_regs

// ==== verilog/plpd_ctrl_regs.v ====
// pll lock settings and power-down control register bank
`timescale 1ns/1ps
`include "plpd_defines.vh"

// Summary of operation
// - lock override bit resets to 0; 0 automatic lock, 1 manual lock
// - manual mode uses 5-bit lock value 01011b and 3-bit oscillator 001b
// - 5-bit pump current code resets to zero and drives the charge pump
// - power-down controls sit in four consecutive bytes 006D to 0070
// - each reference input has a disable bit, reset 0, 1 disables it
// - release mode 0 clears alarm on lock; 1 also needs stable outputs
// - doubler bypass 0 feeds doubled crystal, 1 feeds plain crystal
// - four output disable bits, reset 0; 1 disables output and drivers
// - digital loop disable bit, reset 0; 1 stops the digital loop
// - modulator disable bit, reset 0; 1 disables delta-sigma modulator
// - calibration hold bit, reset 0; 1 holds calibration logic disabled
// - loss of lock sets a sticky flag cleared only by writing one
module plpd_ctrl_regs (
    // clock and reset
    input  wire        clk_sys,
    input  wire        reset_n,
    // configuration port from the serial interface decoder
    input  wire [15:0] cfg_addr,
    input  wire        cfg_wr,
    input  wire [7:0]  cfg_wdata,
    input  wire        cfg_rd,
    output reg  [7:0]  cfg_rdata,
    output reg         cfg_rvalid,
    // status from the analog loop, asynchronous levels
    input  wire        pll_locked_raw,
    input  wire        out_clocks_stable_raw,
    // analog loop lock controls
    output reg         lock_override_mode,
    output reg  [2:0]  manual_oscillator_choice,
    output reg  [4:0]  manual_lock_value,
    output reg  [4:0]  pump_current_code,
    // power-down controls
    output reg  [1:0]  reference_input_off,
    output reg         lock_alarm_release_mode,
    output reg         crystal_doubler_bypass,
    output reg  [3:0]  output_driver_off,
    output reg         digital_loop_off,
    output reg         modulator_off,
    output reg         calibration_hold,
    // lock alarm and its sticky record
    output reg         loss_of_lock_alarm,
    output reg         lock_loss_sticky_flag
);

    wire       pll_locked;
    wire       out_clocks_stable;
    reg        next_alarm;
    reg        clear_sticky;
    reg  [7:0] next_rdata;

    // true when a write hits the given byte address
    function wr_hit;
        input [15:0] addr;
        input        wr;
        input [15:0] target;
        begin
            wr_hit = wr && (addr == target);
        end
    endfunction

    // bring analog status into the configuration clock domain
    // stages reset to locked and stable, so release of reset
    // cannot fake a loss of lock while the stages refill
    plpd_sync2 #(
        .WIDTH     (2),
        .RESET_VAL (2'h3)
    ) u_sync (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .async_in ({out_clocks_stable_raw, pll_locked_raw}),
        .sync_out ({out_clocks_stable, pll_locked})
    );

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lock_override_mode <= `PLPD_RST_LOCK_OVERRIDE;
        end else if (wr_hit(cfg_addr, cfg_wr, `PLPD_ADDR_LOCK_OVERRIDE)) begin
            lock_override_mode <= cfg_wdata[`PLPD_BIT_LOCK_OVERRIDE];
        end
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            manual_oscillator_choice <= `PLPD_RST_VCO_CHOICE;
            manual_lock_value        <= `PLPD_RST_LOCK_VALUE;
        end else if (wr_hit(cfg_addr, cfg_wr, `PLPD_ADDR_MANUAL_VCO)) begin
            manual_oscillator_choice <=
                cfg_wdata[`PLPD_MSB_VCO_CHOICE:`PLPD_LSB_VCO_CHOICE];
            manual_lock_value        <=
                cfg_wdata[`PLPD_MSB_LOCK_VALUE:`PLPD_LSB_LOCK_VALUE];
        end
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pump_current_code <= `PLPD_RST_PUMP_CODE;
        end else if (wr_hit(cfg_addr, cfg_wr, `PLPD_ADDR_PUMP_CURRENT)) begin
            pump_current_code <=
                cfg_wdata[`PLPD_MSB_PUMP_CODE:`PLPD_LSB_PUMP_CODE];
        end
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reference_input_off     <= {2{`PLPD_RST_FLAG}};
            lock_alarm_release_mode <= `PLPD_RST_FLAG;
        end else if (wr_hit(cfg_addr, cfg_wr, `PLPD_ADDR_REF_DISABLE)) begin
            reference_input_off[0]  <= cfg_wdata[`PLPD_BIT_REF0_OFF];
            reference_input_off[1]  <= cfg_wdata[`PLPD_BIT_REF1_OFF];
            lock_alarm_release_mode <= cfg_wdata[`PLPD_BIT_RELEASE_MODE];
        end
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            crystal_doubler_bypass <= `PLPD_RST_FLAG;
        end else if (wr_hit(cfg_addr, cfg_wr, `PLPD_ADDR_DOUBLER_CTRL)) begin
            crystal_doubler_bypass <= cfg_wdata[`PLPD_BIT_DOUBLER_BYPASS];
        end
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            output_driver_off <= `PLPD_RST_OUT_OFF;
        end else if (wr_hit(cfg_addr, cfg_wr, `PLPD_ADDR_OUT_DISABLE)) begin
            output_driver_off <=
                cfg_wdata[`PLPD_MSB_OUT_OFF:`PLPD_LSB_OUT_OFF];
        end
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            digital_loop_off <= `PLPD_RST_FLAG;
            modulator_off    <= `PLPD_RST_FLAG;
            calibration_hold <= `PLPD_RST_FLAG;
        end else if (wr_hit(cfg_addr, cfg_wr, `PLPD_ADDR_BLOCK_DISABLE)) begin
            digital_loop_off <= cfg_wdata[`PLPD_BIT_DIGITAL_OFF];
            modulator_off    <= cfg_wdata[`PLPD_BIT_MODULATOR_OFF];
            calibration_hold <= cfg_wdata[`PLPD_BIT_CAL_HOLD];
        end
    end

    always @* begin
        if (lock_alarm_release_mode) begin
            next_alarm = !(pll_locked && out_clocks_stable);
        end else begin
            next_alarm = !pll_locked;
        end
    end

    // alarm level, re-raised only by loss of lock itself
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            loss_of_lock_alarm <= `PLPD_RST_FLAG;
        end else if (!pll_locked) begin
            loss_of_lock_alarm <= 1'b1;
        end else begin
            loss_of_lock_alarm <= next_alarm && loss_of_lock_alarm;
        end
    end

    // write-one-to-clear request for the sticky flag
    always @* begin
        clear_sticky = wr_hit(cfg_addr, cfg_wr, `PLPD_ADDR_LOCK_STATUS)
                       && cfg_wdata[`PLPD_BIT_LOCK_STICKY];
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lock_loss_sticky_flag <= `PLPD_RST_FLAG;
        end else if (!pll_locked) begin
            lock_loss_sticky_flag <= 1'b1;
        end else if (clear_sticky) begin
            lock_loss_sticky_flag <= 1'b0;
        end
    end

    always @* begin
        next_rdata = 8'h00;
        case (cfg_addr)
            `PLPD_ADDR_LOCK_OVERRIDE:
                next_rdata[`PLPD_BIT_LOCK_OVERRIDE] = lock_override_mode;
            `PLPD_ADDR_MANUAL_VCO: begin
                next_rdata[`PLPD_MSB_VCO_CHOICE:`PLPD_LSB_VCO_CHOICE] =
                    manual_oscillator_choice;
                next_rdata[`PLPD_MSB_LOCK_VALUE:`PLPD_LSB_LOCK_VALUE] =
                    manual_lock_value;
            end
            `PLPD_ADDR_PUMP_CURRENT:
                next_rdata[`PLPD_MSB_PUMP_CODE:`PLPD_LSB_PUMP_CODE] =
                    pump_current_code;
            `PLPD_ADDR_REF_DISABLE: begin
                next_rdata[`PLPD_BIT_REF0_OFF]     = reference_input_off[0];
                next_rdata[`PLPD_BIT_REF1_OFF]     = reference_input_off[1];
                next_rdata[`PLPD_BIT_RELEASE_MODE] = lock_alarm_release_mode;
            end
            `PLPD_ADDR_DOUBLER_CTRL:
                next_rdata[`PLPD_BIT_DOUBLER_BYPASS] = crystal_doubler_bypass;
            `PLPD_ADDR_OUT_DISABLE:
                next_rdata[`PLPD_MSB_OUT_OFF:`PLPD_LSB_OUT_OFF] =
                    output_driver_off;
            `PLPD_ADDR_BLOCK_DISABLE: begin
                next_rdata[`PLPD_BIT_DIGITAL_OFF]   = digital_loop_off;
                next_rdata[`PLPD_BIT_MODULATOR_OFF] = modulator_off;
                next_rdata[`PLPD_BIT_CAL_HOLD]      = calibration_hold;
            end
            `PLPD_ADDR_LOCK_STATUS:
                next_rdata[`PLPD_BIT_LOCK_STICKY] = lock_loss_sticky_flag;
            default:
                next_rdata = 8'h00;
        endcase
    end

    // read data registered one cycle after the read strobe
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cfg_rdata  <= 8'h00;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_rd;
            if (cfg_rd) begin
                cfg_rdata <= next_rdata;
            end
        end
    end

endmodule // plpd_ctrl_regs

// ==== verilog/plpd_defines.vh ====
// register offsets, field positions, reset values for the pll/power-down bank
`ifndef PLPD_DEFINES_VH
`define PLPD_DEFINES_VH

// register byte addresses on the configuration port
`define PLPD_ADDR_LOCK_OVERRIDE   16'h0069
`define PLPD_ADDR_MANUAL_VCO      16'h006A
`define PLPD_ADDR_PUMP_CURRENT    16'h006C
`define PLPD_ADDR_REF_DISABLE     16'h006D
`define PLPD_ADDR_DOUBLER_CTRL    16'h006E
`define PLPD_ADDR_OUT_DISABLE     16'h006F
`define PLPD_ADDR_BLOCK_DISABLE   16'h0070
`define PLPD_ADDR_LOCK_STATUS     16'h0200

// field positions
`define PLPD_BIT_LOCK_OVERRIDE    0
`define PLPD_MSB_VCO_CHOICE       7
`define PLPD_LSB_VCO_CHOICE       5
`define PLPD_MSB_LOCK_VALUE       4
`define PLPD_LSB_LOCK_VALUE       0
`define PLPD_MSB_PUMP_CODE        4
`define PLPD_LSB_PUMP_CODE        0
`define PLPD_BIT_REF0_OFF         0
`define PLPD_BIT_REF1_OFF         1
`define PLPD_BIT_RELEASE_MODE     7
`define PLPD_BIT_DOUBLER_BYPASS   0
`define PLPD_MSB_OUT_OFF          3
`define PLPD_LSB_OUT_OFF          0
`define PLPD_BIT_DIGITAL_OFF      2
`define PLPD_BIT_MODULATOR_OFF    1
`define PLPD_BIT_CAL_HOLD         0
`define PLPD_BIT_LOCK_STICKY      6

// reset values
`define PLPD_RST_LOCK_OVERRIDE    1'h0
`define PLPD_RST_VCO_CHOICE       3'h1
`define PLPD_RST_LOCK_VALUE       5'h0B
`define PLPD_RST_PUMP_CODE        5'h00
`define PLPD_RST_FLAG             1'h0
`define PLPD_RST_OUT_OFF          4'h0

// oscillator choice codes, 3'h2 to 3'h7 reserved
`define PLPD_VCO_FIRST            3'h0
`define PLPD_VCO_SECOND           3'h1

`endif

// ==== verilog/plpd_sync2.v ====
// two-flop synchroniser for status levels coming from the analog loop
`timescale 1ns/1ps

module plpd_sync2 #(
    parameter             WIDTH     = 1,
    // reset level of both stages, chosen as the idle level of the input
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    // clock and reset
    input  wire             clk_sys,
    input  wire             reset_n,
    // asynchronous level in, synchronised level out
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            meta     <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule // plpd_sync2
